// ---- verilog/touch_adc_status_flags.sv ----
// status register and indicator pin logic of the touch converter
`timescale 1ns/10ps
module touch_adc_status_flags
    import touch_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic pen_touch,
    input wire conv_evt_s conv_evt,
    input wire conv_state_s conv_state,
    output logic touch_or_ready_indicator_n,
    output logic touch_or_ready_indicator_oe
);

    logic [1:0] pin_mode_r;
    logic [1:0] pin_mode_nxt;
    logic [CHAN_N-1:0] chan_r;
    logic [CHAN_N-1:0] chan_nxt;
    logic result_set_ready_flag_r;
    logic ready_nxt;
    logic touch_pending_r;
    logic pending_nxt;
    logic pen_meta_r;
    logic pen_sync_r;
    logic halted_r;
    logic owner_r;
    logic ind_r;
    logic ind_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic rvalid_r;

    // place channel flags and levels into the status word
    function automatic logic [DATA_W-1:0] pack_status(
        input logic [1:0] mode,
        input logic halted,
        input logic owner,
        input logic ready,
        input logic [CHAN_N-1:0] ch
    );
        logic [DATA_W-1:0] w;
        w = '0;
        w[MODE_HI_POS:MODE_LO_POS] = mode;
        w[HALTED_POS] = halted;
        w[OWNER_POS] = owner;
        w[READY_POS] = ready;
        w[HORIZ_POS] = ch[CH_HORIZ];
        w[VERT_POS] = ch[CH_VERT];
        w[PRESS_A_POS] = ch[CH_PRESS_A];
        w[PRESS_B_POS] = ch[CH_PRESS_B];
        w[SUPPLY_A_POS] = ch[CH_SUPPLY_A];
        w[SUPPLY_B_POS] = ch[CH_SUPPLY_B];
        w[AUX_POS] = ch[CH_AUX];
        w[THERM_A_POS] = ch[CH_THERM_A];
        w[THERM_B_POS] = ch[CH_THERM_B];
        return w;
    endfunction

    wire status_hit = (reg_addr == CONVERTER_STATUS_OFFSET);
    wire status_wr = reg_wr && status_hit;
    wire status_rd = reg_rd && status_hit;
    wire any_read_done = |conv_evt.read_done;

    // only the pin-function field is writable
    assign pin_mode_nxt = status_wr ? reg_wdata[MODE_HI_POS:MODE_LO_POS]
                                    : pin_mode_r;

    // new result sets a flag even if its read completes in the same cycle
    assign chan_nxt = conv_evt.stored | (chan_r & ~conv_evt.read_done);

    // set ready flag holds until the last outstanding result is read
    assign ready_nxt = conv_evt.set_done
                       | (result_set_ready_flag_r
                          & ~(any_read_done && (chan_nxt == CHAN_RESET)));

    // touch latched for the combined function, released by set completion
    assign pending_nxt = pen_sync_r | (touch_pending_r & ~conv_evt.set_done);

    always_comb
    begin
        unique case (pin_mode_r)
            PIN_TOUCH_ONLY: ind_nxt = ~pen_sync_r;
            PIN_READY_ONLY: ind_nxt = ~ready_nxt;
            default: ind_nxt = ~pending_nxt;
        endcase
    end

    // pen input crosses in from the analog comparator
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pen_meta_r <= 1'b0;
            pen_sync_r <= 1'b0;
        end
        else if (ce)
        begin
            pen_meta_r <= pen_touch;
            pen_sync_r <= pen_meta_r;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_mode_r <= PIN_MODE_RESET;
            chan_r <= CHAN_RESET;
            result_set_ready_flag_r <= 1'b0;
            touch_pending_r <= 1'b0;
            ind_r <= 1'b1;
        end
        else if (ce)
        begin
            pin_mode_r <= pin_mode_nxt;
            chan_r <= chan_nxt;
            result_set_ready_flag_r <= ready_nxt;
            touch_pending_r <= pending_nxt;
            ind_r <= ind_nxt;
        end
    end

    // converter levels sampled once so a read sees a stable word
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            halted_r <= 1'b0;
            owner_r <= 1'b0;
        end
        else if (ce)
        begin
            halted_r <= conv_state.halted;
            owner_r <= conv_state.self_sequenced;
        end
    end

    wire [DATA_W-1:0] status_word = pack_status(pin_mode_r, halted_r, owner_r,
                                                result_set_ready_flag_r, chan_r);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end
        else if (ce)
        begin
            rdata_r <= status_rd ? status_word : '0;
            rvalid_r <= reg_rd;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign touch_or_ready_indicator_n = ind_r;
    // open-drain style: drive only while pulling low
    assign touch_or_ready_indicator_oe = ~ind_r;

    // ---- checks ----
    property mode_write_p;
        @(posedge clk_sys) disable iff (!nrst)
        (ce && status_wr) |=> pin_mode_r == $past(reg_wdata[MODE_HI_POS:MODE_LO_POS]);
    endproperty
    mode_write_a: assert property (mode_write_p)
        else $error("pin function field not written");

    pen_only_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && pin_mode_r == PIN_TOUCH_ONLY && !status_wr) |=> ind_r == !$past(pen_sync_r))
        else $error("indicator does not follow touch in touch-only function");

    ready_only_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && pin_mode_r == PIN_READY_ONLY && !status_wr && result_set_ready_flag_r
         && !any_read_done) |=> !ind_r)
        else $error("indicator released while results are unread");

    combined_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && pin_mode_r[1] && !status_wr && pen_sync_r) |=> !ind_r ##0 touch_pending_r)
        else $error("touch not shown in combined function");

    chan_set_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ce |=> ((chan_r & $past(conv_evt.stored)) == $past(conv_evt.stored)))
        else $error("stored result did not set its flag");

    chan_hold_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ce |=> ((~chan_r & $past(chan_r) & ~$past(conv_evt.read_done)) == CHAN_RESET))
        else $error("channel flag cleared without a completed read");

    ready_clear_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(result_set_ready_flag_r) |-> (chan_r == CHAN_RESET) && $past(any_read_done))
        else $error("ready flag cleared with results outstanding");

    ready_set_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && conv_evt.set_done) |=> result_set_ready_flag_r)
        else $error("ready flag not set on set completion");

    read_word_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && status_rd) |=> reg_rvalid && reg_rdata[HALTED_POS] == $past(halted_r)
            && reg_rdata[OWNER_POS] == $past(owner_r) && reg_rdata[3] == 1'b0
            && reg_rdata[0] == 1'b0)
        else $error("status word read back wrong");

    cover_ready_only_c: cover property (
        @(posedge clk_sys) disable iff (!nrst)
        pin_mode_r == PIN_READY_ONLY && $fell(ind_r));
    cover_scan_read_c: cover property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(result_set_ready_flag_r));
    cover_set_clear_c: cover property (
        @(posedge clk_sys) disable iff (!nrst)
        ce && |(conv_evt.stored & conv_evt.read_done & chan_r));
    cover_combined_c: cover property (
        @(posedge clk_sys) disable iff (!nrst)
        pin_mode_r[1] && $rose(ind_r));

endmodule

// ---- verilog/touch_status_pkg.sv ----
// shared constants and carriers for the touch converter status block
package touch_status_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int CHAN_N = 9;

    localparam logic [ADDR_W-1:0] CONVERTER_STATUS_OFFSET = 7'h01;

    // status word field positions
    localparam int MODE_HI_POS = 15;
    localparam int MODE_LO_POS = 14;
    localparam int HALTED_POS = 13;
    localparam int OWNER_POS = 12;
    localparam int READY_POS = 11;
    localparam int HORIZ_POS = 10;
    localparam int VERT_POS = 9;
    localparam int PRESS_A_POS = 8;
    localparam int PRESS_B_POS = 7;
    localparam int SUPPLY_A_POS = 6;
    localparam int SUPPLY_B_POS = 5;
    localparam int AUX_POS = 4;
    localparam int THERM_A_POS = 2;
    localparam int THERM_B_POS = 1;

    // indicator pin function encodings
    localparam logic [1:0] PIN_TOUCH_ONLY = 2'h0;
    localparam logic [1:0] PIN_READY_ONLY = 2'h1;
    localparam logic [1:0] PIN_MODE_RESET = 2'h2;

    localparam logic [CHAN_N-1:0] CHAN_RESET = 9'h000;

    // channel index order inside the flag vector
    typedef enum logic [3:0] {
        CH_HORIZ, CH_VERT, CH_PRESS_A, CH_PRESS_B, CH_SUPPLY_A,
        CH_SUPPLY_B, CH_AUX, CH_THERM_A, CH_THERM_B
    } chan_e;

    // converter-side events, one cycle pulses
    typedef struct packed {
        logic set_done;
        logic [CHAN_N-1:0] stored;
        logic [CHAN_N-1:0] read_done;
    } conv_evt_s;

    // converter-side levels
    typedef struct packed {
        logic halted;
        logic self_sequenced;
    } conv_state_s;

endpackage

// ---- testbench/host_model.sv ----
// host and converter stand-in driving the status block
`timescale 1ns/10ps
module host_model
    import touch_status_pkg::*;
(
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    output conv_evt_s conv_evt
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h7E;
        reg_wdata = 16'hA5A5;
        conv_evt = '0;
    end
    // released data lines flip so stale values never look valid
    task automatic wr(input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b1;
        reg_addr = CONVERTER_STATUS_OFFSET;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask
    task automatic evt(input conv_evt_s e);
        @(posedge clk_sys);
        #1;
        conv_evt = e;
        @(posedge clk_sys);
        #1;
        conv_evt = '0;
    endtask
endmodule

// ---- testbench/tb_touch_adc_status_flags.sv ----
// self-checking bench for the touch converter status block
`timescale 1ns/10ps
module tb_touch_adc_status_flags;
    import touch_status_pkg::*;
    logic clk_sys, nrst, pen_touch, reg_wr, reg_rd, reg_rvalid, ind_n, ind_oe;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, got;
    conv_evt_s conv_evt;
    conv_state_s conv_state;
    int miscompares;
    int n_tests;
    touch_adc_status_flags dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pen_touch(pen_touch),
        .conv_evt(conv_evt), .conv_state(conv_state),
        .touch_or_ready_indicator_n(ind_n), .touch_or_ready_indicator_oe(ind_oe));
    host_model host_u (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .conv_evt(conv_evt));
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_pin(input logic exp);
        chk("indicator", {15'h0, exp}, {15'h0, ind_n});
        chk("indicator enable", {15'h0, ~exp}, {15'h0, ind_oe});
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic conv_evt_s mk(input logic s, input int st, input int rdn);
        conv_evt_s e;
        e = '0;
        e.set_done = s;
        if (st >= 0) e.stored[st] = 1'b1;
        if (rdn >= 0) e.read_done[rdn] = 1'b1;
        return e;
    endfunction
    function automatic logic [15:0] flag(input int i);
        return 16'h0001 << ((i < 7) ? 10 - i : 9 - i);
    endfunction
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_regs;
        host_u.rd(CONVERTER_STATUS_OFFSET, got);
        chk("status", 16'h8000, got);
        chk_pin(1'b1);
        host_u.wr(16'h7FFF);
        host_u.rd(CONVERTER_STATUS_OFFSET, got);
        chk("status", 16'h4000, got);
        conv_state = '{halted: 1'b1, self_sequenced: 1'b0};
        host_u.rd(CONVERTER_STATUS_OFFSET, got);
        chk("status", 16'h6000, got);
        conv_state = '{halted: 1'b0, self_sequenced: 1'b1};
        host_u.rd(CONVERTER_STATUS_OFFSET, got);
        chk("status", 16'h5000, got);
        conv_state = '0;
        host_u.rd(7'h02, got);
        chk("other address", 16'h0000, got);
    endtask
    // ready-only pin function, every channel set then read
    task automatic t_chan;
        for (int i = 0; i < CHAN_N; i++)
        begin
            host_u.evt(mk(1'b1, i, -1));
            chk_pin(1'b0);
            host_u.rd(CONVERTER_STATUS_OFFSET, got);
            chk("status", 16'h4800 | flag(i), got);
            chk_pin(1'b0);
            host_u.evt(mk(1'b0, -1, i));
            host_u.rd(CONVERTER_STATUS_OFFSET, got);
            chk("status", 16'h4000, got);
            chk_pin(1'b1);
        end
    endtask
    task automatic t_partial;
        host_u.evt(mk(1'b1, 0, -1));
        host_u.evt(mk(1'b0, 1, 0));
        host_u.rd(CONVERTER_STATUS_OFFSET, got);
        chk("status", 16'h4A00, got);
        chk_pin(1'b0);
        host_u.evt(mk(1'b0, -1, 1));
        wait_n(2);
        chk_pin(1'b1);
    endtask
    task automatic t_touch_only;
        host_u.wr(16'h0000);
        pen_touch = 1'b1;
        wait_n(4);
        chk_pin(1'b0);
        pen_touch = 1'b0;
        host_u.evt(mk(1'b1, 6, -1));
        wait_n(4);
        chk_pin(1'b1);
        host_u.evt(mk(1'b0, -1, 6));
    endtask
    task automatic t_both;
        for (int m = 2; m < 4; m++)
        begin
            host_u.wr({m[1:0], 14'h0000});
            pen_touch = 1'b1;
            wait_n(4);
            chk_pin(1'b0);
            pen_touch = 1'b0;
            wait_n(4);
            chk_pin(1'b0);
            host_u.evt(mk(1'b1, 7, -1));
            wait_n(2);
            chk_pin(1'b1);
            host_u.evt(mk(1'b0, -1, 7));
        end
    endtask
    task automatic t_midreset;
        host_u.evt(mk(1'b1, 8, -1));
        nrst = 1'b0;
        wait_n(2);
        nrst = 1'b1;
        host_u.rd(CONVERTER_STATUS_OFFSET, got);
        chk("status", 16'h8000, got);
        chk_pin(1'b1);
    endtask
    initial
    begin
        nrst = 1'b0;
        pen_touch = 1'b0;
        conv_state = '0;
        miscompares = 0;
        n_tests = 0;
        wait_n(5);
        nrst = 1'b1;
        t_regs();
        t_chan();
        t_partial();
        t_touch_only();
        t_both();
        t_midreset();
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        give_verdict();
    end
endmodule
